//--- design/nbbm_top.sv
`timescale 1ns/100ps

// ==========================================================
// small elastic buffer between data source and the flash writer
module nbbm_fifo import nbbm_pkg::*; #(
  parameter int W = FIFO_W,
  parameter int DEPTH = FIFO_DEPTH
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic [W-1:0] inData,
  input wire logic inValid,
  output logic inReady,
  output logic [W-1:0] outData,
  output logic outValid,
  input wire logic outReady
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [CW-1:0] cnt;
    logic notFull;
  } nbbm_fifo_s;
  nbbm_fifo_s s_ff, nxt_s;
  logic [W-1:0] mem [DEPTH];
  logic push, pop;

  // depth must be a power of two so the pointers wrap by themselves
  always_comb begin
    nxt_s = s_ff;
    push = inValid && s_ff.notFull;
    pop = outReady && (s_ff.cnt != '0);
    if (push) nxt_s.wp = s_ff.wp + 1'b1;
    if (pop) nxt_s.rp = s_ff.rp + 1'b1;
    nxt_s.cnt = s_ff.cnt + CW'(push) - CW'(pop);
    nxt_s.notFull = nxt_s.cnt != CW'(DEPTH);
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) s_ff <= '{wp: '0, rp: '0, cnt: '0, notFull: 1'b1};
    else s_ff <= nxt_s;
  end

  // storage needs no reset, the count guards it
  always_ff @(posedge sys_clk) begin
    if (push) mem[s_ff.wp] <= inData;
  end

  assign inReady = s_ff.notFull;
  assign outValid = s_ff.cnt != '0;
  assign outData = mem[s_ff.rp];
endmodule

// ==========================================================
// bad-block sequencer
module nbbm_top import nbbm_pkg::*; (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire nbbm_cfg_s cfg,
  input wire logic opStart,
  input wire nbbm_cmd_e opCmd,
  input wire logic [LEFT_W-1:0] progPages,
  input wire logic [FIFO_W-1:0] dataIn,
  input wire logic dataInValid,
  output logic dataInReady,
  output nbbm_req_s flashReq,
  output logic flashReqValid,
  input wire logic flashReqReady,
  input wire logic flashDone,
  input wire logic [15:0] flashRdData,
  output logic [15:0] flashWrData,
  output logic flashWrValid,
  input wire logic flashWrReady,
  input wire logic [MAP_AW-1:0] mapRdAddr,
  output logic [7:0] mapRdData,
  output logic [7:0] fillValue,
  output logic busy,
  output logic opDone,
  output logic opErr
);
  typedef enum logic [4:0] {
    ST_IDLE = 5'h00, ST_CLR = 5'h01, ST_SCAN_REQ = 5'h02,
    ST_SCAN_WAIT = 5'h03, ST_TBL_FIND = 5'h04, ST_TBL_DATA = 5'h05,
    ST_TBL_WAIT = 5'h06, ST_WR_SEEK = 5'h07, ST_WR_RES = 5'h08,
    ST_WR_DATA = 5'h09, ST_WR_WAIT = 5'h0A, ST_ER_REQ = 5'h0B,
    ST_ER_WAIT = 5'h0C, ST_RS_SEEK = 5'h0D, ST_RS_DATA = 5'h0E,
    ST_RS_WAIT = 5'h0F
  } nbbm_state_e;

  typedef struct packed {
    nbbm_state_e st;
    nbbm_cmd_e cmd;
    logic [MAP_AW-1:0] clr;
    logic [BLK_W-1:0] blk;
    logic [BLK_W-1:0] ub;
    logic [BLK_W-1:0] res;
    logic [PG_W-1:0] page;
    logic [UNIT_W-1:0] unit;
    logic [LEFT_W-1:0] left;
    logic [UNIT_W-1:0] fIdx;
    logic [15:0] count;
    logic phase;
    logic copy;
    nbbm_req_s req;
    logic reqValid;
    logic [15:0] wrData;
    logic wrValid;
    logic [7:0] mapRd;
    logic [7:0] fill;
    logic busy;
    logic done;
    logic err;
  } nbbm_state_s;

  nbbm_state_s s_ff, nxt_s;
  logic badBit [MAX_BLOCKS];
  logic memWe, memVal, clrWe, fifoValid, fifoReady, emitOk, stepSearch;
  logic [11:0] memIdx;
  logic [FIFO_W-1:0] fifoData;
  logic [15:0] fld;

  // ==========================================================
  // geometry decode
  function automatic logic [UNIT_W-1:0] pageUnits(nbbm_cfg_s c);
    if (!c.largePage) return c.wide16 ? SP16_PAGE : SP8_PAGE;
    if (c.page4k) return c.wide16 ? XP16_PAGE : XP8_PAGE;
    return c.wide16 ? LP16_PAGE : LP8_PAGE;
  endfunction

  function automatic logic [UNIT_W-1:0] spareUnits(nbbm_cfg_s c);
    if (!c.largePage) return c.wide16 ? SP16_SPARE : SP8_SPARE;
    return c.wide16 ? LP16_SPARE : LP8_SPARE;
  endfunction

  function automatic logic [UNIT_W-1:0] markOff(nbbm_cfg_s c);
    if (c.wide16) return MARK_OFF_0;
    if (!c.largePage) return MARK_OFF_5;
    return c.mark5 ? MARK_OFF_5 : MARK_OFF_0;
  endfunction

  // pages per block is 2^ppbLog2
  function automatic logic [PG_W-1:0] lastPage(nbbm_cfg_s c);
    return PG_W'((8'h01 << c.ppbLog2) - 8'h01);
  endfunction

  // blocks past the supported range count as bad so skip and remap page writes never land there
  function automatic logic badAt(logic [BLK_W-1:0] b);
    return (b >= BLK_W'(MAX_BLOCKS)) ? 1'b1 : badBit[b[11:0]];
  endfunction

  // 8-bit arrays carry one byte per beat in the low lane
  function automatic logic [15:0] beat(nbbm_cfg_s c, logic [15:0] w,
                                       logic hi);
    if (c.wide16) return w;
    return {8'h00, hi ? w[15:8] : w[7:0]};
  endfunction

  function automatic nbbm_req_s mkReq(nbbm_fop_e op,
      logic [BLK_W-1:0] b, logic [PG_W-1:0] p,
      logic [UNIT_W-1:0] col, logic [UNIT_W-1:0] len);
    return '{op: op, block: b, page: p, col: col, len: len};
  endfunction

  function automatic nbbm_state_s finish(nbbm_state_s x);
    x.st = ST_IDLE;
    x.busy = 1'b0;
    x.done = 1'b1;
    return x;
  endfunction

  function automatic nbbm_state_s startWrite(nbbm_state_s x,
                                             nbbm_cfg_s c);
    x.blk = '0;
    x.page = '0;
    x.left = progPages;
    x.res = c.reservoirStart;
    x.st = ST_WR_SEEK;
    return x;
  endfunction

  nbbm_fifo #(.W(FIFO_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .inData(dataIn),
    .inValid(dataInValid),
    .inReady(dataInReady),
    .outData(fifoData),
    .outValid(fifoValid),
    .outReady(fifoReady)
  );

  // ==========================================================
  // next-state logic
  always_comb begin
    nxt_s = s_ff;
    nxt_s.done = 1'b0;
    memWe = 1'b0;
    memVal = 1'b0;
    memIdx = s_ff.blk[11:0];
    clrWe = 1'b0;
    fifoReady = 1'b0;
    stepSearch = 1'b0;
    fld = ERASED_WORD;
    emitOk = !s_ff.wrValid || flashWrReady;
    if (s_ff.reqValid && flashReqReady) nxt_s.reqValid = 1'b0;
    if (s_ff.wrValid && flashWrReady) nxt_s.wrValid = 1'b0;
    for (int i = 0; i < 8; i++) begin
      nxt_s.mapRd[i] = badBit[{mapRdAddr, 3'(i)}];
    end
    nxt_s.fill = cfg.fillF0 ? FILL_F0 : FILL_00;
    unique case (s_ff.st)
      ST_IDLE: if (opStart) begin
        nxt_s.err = 1'b0;
        nxt_s.busy = 1'b1;
        nxt_s.cmd = opCmd;
        nxt_s.clr = '0;
        nxt_s.blk = '0;
        if (cfg.mode == MODE_NONE && opCmd == CMD_PROG)
          nxt_s = startWrite(nxt_s, cfg);
        else if (cfg.mode == MODE_NONE && opCmd == CMD_ERASE)
          nxt_s.st = ST_ER_REQ;
        else
          nxt_s.st = ST_CLR;
      end
      // wipe the map a byte per cycle so stale marks never survive
      ST_CLR: begin
        clrWe = 1'b1;
        nxt_s.clr = s_ff.clr + 1'b1;
        if (s_ff.clr == MAP_AW'(MAP_BYTES - 1)) nxt_s.st = ST_SCAN_REQ;
      end
      ST_SCAN_REQ: if (s_ff.blk == cfg.blockCount) begin
        if (s_ff.cmd == CMD_ERASE) begin
          nxt_s.blk = '0;
          nxt_s.st = ST_ER_REQ;
        end else if (s_ff.cmd == CMD_PROG && cfg.mode == MODE_REMAP) begin
          nxt_s.copy = 1'b0;
          nxt_s.blk = cfg.remapTableStart;
          nxt_s.st = ST_TBL_FIND;
        end else if (s_ff.cmd == CMD_PROG) begin
          nxt_s = startWrite(nxt_s, cfg);
        end else begin
          nxt_s = finish(nxt_s);
        end
      end else begin
        nxt_s.req = mkReq(FOP_READ_SPARE, s_ff.blk, '0,
          pageUnits(cfg) + markOff(cfg), 13'h0001);
        nxt_s.reqValid = 1'b1;
        nxt_s.st = ST_SCAN_WAIT;
      end
      ST_SCAN_WAIT: if (flashDone) begin
        memWe = 1'b1;
        memVal = cfg.wide16 ? (flashRdData != ERASED_WORD)
                            : (flashRdData[7:0] != ERASED_BYTE);
        nxt_s.blk = s_ff.blk + 1'b1;
        nxt_s.st = ST_SCAN_REQ;
      end
      // table block is the next good one in the table area
      ST_TBL_FIND: if (s_ff.blk >= cfg.blockCount) begin
        nxt_s.err = 1'b1;
        nxt_s = finish(nxt_s);
      end else if (badAt(s_ff.blk)) begin
        nxt_s.blk = s_ff.blk + 1'b1;
      end else begin
        nxt_s.ub = '0;
        nxt_s.res = cfg.reservoirStart;
        nxt_s.count = MAP_SEQ_FIRST;
        nxt_s.page = '0;
        nxt_s.fIdx = '0;
        nxt_s.unit = '0;
        nxt_s.phase = 1'b0;
        nxt_s.req = mkReq(FOP_PROG, s_ff.blk, '0, '0, pageUnits(cfg));
        nxt_s.reqValid = 1'b1;
        nxt_s.st = ST_TBL_DATA;
      end
      // fields are built on the fly; searching costs a cycle per block
      ST_TBL_DATA: begin
        if (s_ff.fIdx == '0) fld = MAP_MARKER;
        else if (s_ff.fIdx == 13'h0001) fld = s_ff.count;
        else if (s_ff.ub >= cfg.reservoirStart) fld = ERASED_WORD;
        else if (!s_ff.fIdx[0]) begin
          stepSearch = !badAt(s_ff.ub);
          fld = 16'(s_ff.ub);
        end else if (s_ff.res >= cfg.remapTableStart) fld = ERASED_WORD;
        else begin
          stepSearch = badAt(s_ff.res);
          fld = 16'(s_ff.res);
        end
        if (stepSearch) begin
          if (!s_ff.fIdx[0]) nxt_s.ub = s_ff.ub + 1'b1;
          else nxt_s.res = s_ff.res + 1'b1;
        end else if (emitOk) begin
          nxt_s.wrValid = 1'b1;
          nxt_s.wrData = beat(cfg, fld, s_ff.phase);
          nxt_s.phase = !cfg.wide16 && !s_ff.phase;
          nxt_s.unit = s_ff.unit + 1'b1;
          if (cfg.wide16 || s_ff.phase) begin
            nxt_s.fIdx = s_ff.fIdx + 1'b1;
            if (s_ff.fIdx[0] && s_ff.fIdx != 13'h0001 &&
                s_ff.ub < cfg.reservoirStart) begin
              nxt_s.ub = s_ff.ub + 1'b1;
              if (s_ff.res < cfg.remapTableStart)
                nxt_s.res = s_ff.res + 1'b1;
              else nxt_s.err = 1'b1;
            end
          end
          if (s_ff.unit == pageUnits(cfg) - 1'b1) nxt_s.st = ST_TBL_WAIT;
        end
      end
      ST_TBL_WAIT: if (flashDone) begin
        if (s_ff.ub < cfg.reservoirStart) begin
          nxt_s.page = s_ff.page + 1'b1;
          nxt_s.count = s_ff.count + 1'b1;
          nxt_s.fIdx = '0;
          nxt_s.unit = '0;
          nxt_s.req = mkReq(FOP_PROG, s_ff.blk, s_ff.page + 1'b1, '0,
                            pageUnits(cfg));
          nxt_s.reqValid = 1'b1;
          nxt_s.st = ST_TBL_DATA;
        end else if (!s_ff.copy) begin
          nxt_s.copy = 1'b1;
          nxt_s.blk = s_ff.blk + 1'b1;
          nxt_s.st = ST_TBL_FIND;
        end else begin
          nxt_s = startWrite(nxt_s, cfg);
        end
      end
      ST_WR_SEEK: if (s_ff.left == '0) begin
        nxt_s = finish(nxt_s);
      end else if (s_ff.blk >= ((cfg.mode == MODE_REMAP) ?
                   cfg.reservoirStart : cfg.blockCount)) begin
        nxt_s.err = 1'b1;
        nxt_s = finish(nxt_s);
      end else if (cfg.mode == MODE_SKIP && badAt(s_ff.blk)) begin
        nxt_s.blk = s_ff.blk + 1'b1;
      end else if (cfg.mode == MODE_REMAP && badAt(s_ff.blk)) begin
        nxt_s.st = ST_WR_RES;
      end else begin
        nxt_s.ub = s_ff.blk;
        nxt_s.unit = '0;
        nxt_s.req = mkReq(FOP_PROG, s_ff.blk, '0, '0, pageUnits(cfg));
        nxt_s.reqValid = 1'b1;
        nxt_s.st = ST_WR_DATA;
      end
      // same allocation order as the table, so both agree
      ST_WR_RES: if (s_ff.res >= cfg.remapTableStart) begin
        nxt_s.err = 1'b1;
        nxt_s = finish(nxt_s);
      end else if (badAt(s_ff.res)) begin
        nxt_s.res = s_ff.res + 1'b1;
      end else begin
        nxt_s.ub = s_ff.res;
        nxt_s.res = s_ff.res + 1'b1;
        nxt_s.unit = '0;
        nxt_s.req = mkReq(FOP_PROG, s_ff.res, '0, '0, pageUnits(cfg));
        nxt_s.reqValid = 1'b1;
        nxt_s.st = ST_WR_DATA;
      end
      // page data goes to column 0 only; spare stays untouched
      ST_WR_DATA: if (emitOk && fifoValid) begin
        fifoReady = 1'b1;
        nxt_s.wrValid = 1'b1;
        nxt_s.wrData = beat(cfg, fifoData, 1'b0);
        nxt_s.unit = s_ff.unit + 1'b1;
        if (s_ff.unit == pageUnits(cfg) - 1'b1) nxt_s.st = ST_WR_WAIT;
      end
      ST_WR_WAIT: if (flashDone) begin
        nxt_s.left = s_ff.left - 1'b1;
        nxt_s.unit = '0;
        if (s_ff.page == lastPage(cfg)) begin
          nxt_s.page = '0;
          nxt_s.blk = s_ff.blk + 1'b1;
          nxt_s.st = ST_WR_SEEK;
        end else if (s_ff.left == 16'h0001) begin
          nxt_s = finish(nxt_s);
        end else begin
          nxt_s.page = s_ff.page + 1'b1;
          nxt_s.req = mkReq(FOP_PROG, s_ff.ub, s_ff.page + 1'b1, '0,
                            pageUnits(cfg));
          nxt_s.reqValid = 1'b1;
          nxt_s.st = ST_WR_DATA;
        end
      end
      ST_ER_REQ: if (s_ff.blk == cfg.blockCount) begin
        nxt_s.blk = '0;
        if (cfg.mode == MODE_NONE) nxt_s = finish(nxt_s);
        else nxt_s.st = ST_RS_SEEK;
      end else begin
        nxt_s.req = mkReq(FOP_ERASE, s_ff.blk, '0, '0, '0);
        nxt_s.reqValid = 1'b1;
        nxt_s.st = ST_ER_WAIT;
      end
      ST_ER_WAIT: if (flashDone) begin
        nxt_s.blk = s_ff.blk + 1'b1;
        nxt_s.st = ST_ER_REQ;
      end
      ST_RS_SEEK: if (s_ff.blk == cfg.blockCount) begin
        nxt_s = finish(nxt_s);
      end else if (!badAt(s_ff.blk)) begin
        nxt_s.blk = s_ff.blk + 1'b1;
      end else begin
        nxt_s.unit = '0;
        nxt_s.req = mkReq(FOP_PROG, s_ff.blk, '0, pageUnits(cfg),
                          spareUnits(cfg));
        nxt_s.reqValid = 1'b1;
        nxt_s.st = ST_RS_DATA;
      end
      // whole spare rewritten: erased except the marker unit
      ST_RS_DATA: if (emitOk) begin
        nxt_s.wrValid = 1'b1;
        nxt_s.wrData = beat(cfg, (s_ff.unit == markOff(cfg)) ?
                            BAD_MARK : ERASED_WORD, 1'b0);
        nxt_s.unit = s_ff.unit + 1'b1;
        if (s_ff.unit == spareUnits(cfg) - 1'b1) nxt_s.st = ST_RS_WAIT;
      end
      ST_RS_WAIT: if (flashDone) begin
        nxt_s.blk = s_ff.blk + 1'b1;
        nxt_s.st = ST_RS_SEEK;
      end
      default: nxt_s.st = ST_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) s_ff <= '0;
    else s_ff <= nxt_s;
  end

  // map storage: bulk clear by byte, scan sets one bit per block
  always_ff @(posedge sys_clk) begin
    if (clrWe) begin
      for (int i = 0; i < 8; i++) begin
        badBit[{s_ff.clr, 3'(i)}] <= 1'b0;
      end
    end else if (memWe) begin
      badBit[memIdx] <= memVal;
    end
  end

  assign flashReq = s_ff.req;
  assign flashReqValid = s_ff.reqValid;
  assign flashWrData = s_ff.wrData;
  assign flashWrValid = s_ff.wrValid;
  assign mapRdData = s_ff.mapRd;
  assign fillValue = s_ff.fill;
  assign busy = s_ff.busy;
  assign opDone = s_ff.done;
  assign opErr = s_ff.err;

  // ==========================================================
  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  scan_col_a: assert property ($rose(s_ff.reqValid) &&
      s_ff.req.op == FOP_READ_SPARE && !cfg.wide16 && !cfg.largePage
      |-> s_ff.req.col == 13'h0205) else $error("scan column wrong");
  bad_mark_a: assert property (s_ff.st == ST_SCAN_WAIT && flashDone &&
      !cfg.wide16 && flashRdData[7:0] == ERASED_BYTE
      |=> s_ff.st == ST_SCAN_REQ ##0 !badBit[memIdx - 12'h001])
      else $error("good block marked bad");
  // restore writes aim at bad blocks on purpose, so only page data counts
  skip_bad_a: assert property ($rose(s_ff.reqValid) &&
      s_ff.req.op == FOP_PROG && cfg.mode == MODE_SKIP &&
      s_ff.st == ST_WR_DATA
      |-> !badAt(s_ff.req.block)) else $error("write to bad block");
  remap_res_a: assert property ($rose(s_ff.reqValid) &&
      s_ff.st == ST_WR_DATA && cfg.mode == MODE_REMAP &&
      s_ff.req.block >= cfg.reservoirStart
      |-> s_ff.req.block < cfg.remapTableStart && !badAt(s_ff.req.block))
      else $error("bad replacement block");
  tbl_marker_a: assert property (s_ff.st == ST_TBL_DATA &&
      s_ff.fIdx == '0 && emitOk && cfg.wide16
      |=> s_ff.wrValid && s_ff.wrData == MAP_MARKER)
      else $error("table marker wrong");
  tbl_count_a: assert property (s_ff.st == ST_TBL_FIND &&
      !badAt(s_ff.blk) && s_ff.blk < cfg.blockCount
      |=> s_ff.count == MAP_SEQ_FIRST && s_ff.page == '0)
      else $error("first sequence count wrong");
  clr_scan_a: assert property (s_ff.st == ST_CLR &&
      s_ff.clr == MAP_AW'(MAP_BYTES - 1)
      |=> s_ff.st == ST_SCAN_REQ && s_ff.blk == '0)
      else $error("scan did not follow clear");
  main_only_a: assert property ($rose(s_ff.reqValid) &&
      s_ff.st == ST_WR_DATA |-> s_ff.req.col == '0 &&
      s_ff.req.len == pageUnits(cfg)) else $error("data aimed at spare");
  restore_a: assert property ($rose(s_ff.reqValid) &&
      s_ff.st == ST_RS_DATA |-> s_ff.req.col == pageUnits(cfg) &&
      s_ff.req.len == spareUnits(cfg)) else $error("restore misplaced");
  // one cycle of slack so the flop may leave reset first
  fill_a: assert property (cfg.fillF0 ##1 cfg.fillF0
      |=> fillValue == FILL_F0) else $error("fill value wrong");

  scan_done_c: cover property (s_ff.st == ST_SCAN_REQ &&
      s_ff.blk == cfg.blockCount && s_ff.blk != '0);
  tbl_copy_c: cover property (s_ff.st == ST_TBL_WAIT && s_ff.copy &&
      flashDone);
  skip_c: cover property (s_ff.st == ST_WR_SEEK &&
      cfg.mode == MODE_SKIP && badAt(s_ff.blk));
  restore_c: cover property (s_ff.st == ST_RS_WAIT && flashDone);
endmodule

//--- design/nbbm_pkg.sv
package nbbm_pkg;
  // ==========================================================
  // sizes and widths
  localparam int BLK_W = 13;
  localparam int MAX_BLOCKS = 4096;
  localparam int MAP_BYTES = (MAX_BLOCKS + 7) / 8;
  localparam int MAP_AW = 9;
  localparam int UNIT_W = 13;
  localparam int PG_W = 7;
  localparam int LEFT_W = 16;
  localparam int FIFO_W = 16;
  localparam int FIFO_DEPTH = 4;

  // ==========================================================
  // page and spare geometry, in array units (bytes or words)
  localparam logic [UNIT_W-1:0] SP8_PAGE = 13'h0200;
  localparam logic [UNIT_W-1:0] SP16_PAGE = 13'h0100;
  localparam logic [UNIT_W-1:0] LP8_PAGE = 13'h0800;
  localparam logic [UNIT_W-1:0] LP16_PAGE = 13'h0400;
  localparam logic [UNIT_W-1:0] XP8_PAGE = 13'h1000;
  localparam logic [UNIT_W-1:0] XP16_PAGE = 13'h0800;
  localparam logic [UNIT_W-1:0] SP8_SPARE = 13'h0010;
  localparam logic [UNIT_W-1:0] SP16_SPARE = 13'h0008;
  localparam logic [UNIT_W-1:0] LP8_SPARE = 13'h0040;
  localparam logic [UNIT_W-1:0] LP16_SPARE = 13'h0020;
  localparam logic [UNIT_W-1:0] MARK_OFF_5 = 13'h0005;
  localparam logic [UNIT_W-1:0] MARK_OFF_0 = 13'h0000;

  // ==========================================================
  // data values
  localparam logic [15:0] MAP_MARKER = 16'hFDFE;
  localparam logic [15:0] MAP_SEQ_FIRST = 16'h0001;
  localparam logic [15:0] ERASED_WORD = 16'hFFFF;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;
  localparam logic [15:0] BAD_MARK = 16'h0000;
  localparam logic [7:0] FILL_00 = 8'h00;
  localparam logic [7:0] FILL_F0 = 8'hF0;

  // ==========================================================
  // modes, commands, flash operations
  typedef enum logic [1:0] {
    MODE_NONE = 2'h0,
    MODE_SKIP = 2'h1,
    MODE_REMAP = 2'h2
  } nbbm_mode_e;

  typedef enum logic [1:0] {
    CMD_SCAN = 2'h0,
    CMD_PROG = 2'h1,
    CMD_ERASE = 2'h2
  } nbbm_cmd_e;

  typedef enum logic [1:0] {
    FOP_READ_SPARE = 2'h0,
    FOP_PROG = 2'h1,
    FOP_ERASE = 2'h2
  } nbbm_fop_e;

  typedef struct packed {
    nbbm_mode_e mode;
    logic largePage;
    logic page4k;
    logic wide16;
    logic mark5;
    logic [2:0] ppbLog2;
    logic fillF0;
    logic [BLK_W-1:0] blockCount;
    logic [BLK_W-1:0] reservoirStart;
    logic [BLK_W-1:0] remapTableStart;
  } nbbm_cfg_s;

  typedef struct packed {
    nbbm_fop_e op;
    logic [BLK_W-1:0] block;
    logic [PG_W-1:0] page;
    logic [UNIT_W-1:0] col;
    logic [UNIT_W-1:0] len;
  } nbbm_req_s;
endpackage

//--- design/nbbm_dummy_unused.sv
`timescale 1ns/100ps

//--- tb/nbbm_flash_model.sv
`timescale 1ns/100ps
// =====
// flash model: one request at a time, answers after LAT cycles
module nbbm_flash_model import nbbm_pkg::*; #(
  parameter int LAT = 3
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire nbbm_req_s flashReq,
  input wire logic flashReqValid,
  output logic flashReqReady,
  output logic flashDone,
  output logic [15:0] flashRdData,
  input wire logic flashWrValid,
  output logic flashWrReady,
  input wire logic [15:0] badMask
);
  logic act;
  int cnt, nb;
  nbbm_req_s rq;
  assign flashReqReady = !act;
  assign flashWrReady = act && rq.op == FOP_PROG && nb < rq.len;
  // beats first, then latency; stale read data flips every cycle
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      act <= 1'b0;
      flashDone <= 1'b0;
      flashRdData <= 16'h5A5A;
    end else begin
      flashDone <= 1'b0;
      flashRdData <= ~flashRdData;
      if (!act && flashReqValid) begin
        act <= 1'b1;
        rq <= flashReq;
        cnt <= LAT;
        nb <= 0;
      end else if (flashWrReady) begin
        if (flashWrValid) nb <= nb + 1;
      end else if (act && cnt > 0) cnt <= cnt - 1;
      else if (act) begin
        act <= 1'b0;
        flashDone <= 1'b1;
        flashRdData <= badMask[rq.block[3:0]] ? 16'h0000 : 16'hFFFF;
      end
    end
  end
endmodule

//--- tb/nand_bad_block_manager_tb.sv
`timescale 1ns/100ps
// =====
// bench: 16 blocks, 2 pages each, blocks 1 and 8 bad
module nand_bad_block_manager_tb import nbbm_pkg::*;;
  logic sys_clk = 1'b0;
  logic rstn, opStart, dataInValid, flashReqValid, flashReqReady;
  logic flashDone, flashWrValid, flashWrReady, busy, opDone, opErr;
  logic dataInReady;
  logic rsMode = 1'b0;
  nbbm_cfg_s cfg;
  nbbm_cmd_e opCmd;
  nbbm_req_s flashReq;
  logic [15:0] progPages, dataIn, flashRdData, flashWrData;
  logic [8:0] mapRdAddr;
  logic [7:0] mapRdData, fillValue;
  logic [12:0] expBlk [3] = '{13'h0000, 13'h0000, 13'h0002};
  int errCount = 0, nTests = 0, pIdx = 0, bIdx = 0, nErase = 0;
  nbbm_top nbbm_top_inst (.sys_clk, .rstn, .cfg, .opStart, .opCmd,
    .progPages, .dataIn, .dataInValid, .dataInReady, .flashReq,
    .flashReqValid, .flashReqReady, .flashDone, .flashRdData,
    .flashWrData, .flashWrValid, .flashWrReady, .mapRdAddr, .mapRdData,
    .fillValue, .busy, .opDone, .opErr);
  nbbm_flash_model nbbm_flash_model_inst (.sys_clk, .rstn, .flashReq,
    .flashReqValid, .flashReqReady, .flashDone, .flashRdData,
    .flashWrValid, .flashWrReady, .badMask(16'h0102));
  initial begin
    forever #12.5 sys_clk = ~sys_clk;
  end
  task automatic chk(input string nm, input logic [15:0] s, e);
    nTests++;
    if (s !== e) begin
      errCount++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask
  // every accepted read or program request is judged as it goes out; erase requests are only counted
  always @(posedge sys_clk) begin
    if (flashReqValid && flashReqReady) begin
      if (flashReq.op == FOP_READ_SPARE)
        chk("col", 16'(flashReq.col), 16'h0205);
      else if (flashReq.op == FOP_PROG && rsMode) begin
        chk("rblk", 16'(flashReq.block), pIdx ? 16'h0008 : 16'h0001);
        chk("rcol", 16'(flashReq.col), 16'h0200);
        chk("rlen", 16'(flashReq.len), 16'h0010);
        pIdx++;
      end else if (flashReq.op == FOP_ERASE)
        nErase++;
      else if (flashReq.op == FOP_PROG) begin
        chk("blk", 16'(flashReq.block), 16'(expBlk[pIdx]));
        chk("len", 16'(flashReq.len), 16'h0200);
        pIdx++;
      end
    end
    // restored spare: erased units, marker unit 5 written as 00
    if (flashWrValid && flashWrReady && rsMode) begin
      chk("rbeat", flashWrData, (bIdx == 5) ? 16'h0000 : 16'h00FF);
      bIdx = (bIdx + 1) % 16;
    end else if (flashWrValid && flashWrReady)
      chk("beat", flashWrData, 16'h00A5);
  end
  task automatic run(input nbbm_cmd_e c);
    int n;
    @(posedge sys_clk);
    opCmd <= c;
    opStart <= 1'b1;
    @(posedge sys_clk);
    opStart <= 1'b0;
    for (n = 0; n < 8000 && opDone !== 1'b1; n++) @(posedge sys_clk) #1;
    chk("done", 16'(opDone), 16'h0001);
    chk("err", 16'(opErr), 16'h0000);
  endtask
  task automatic mapChk(input logic [8:0] a, input logic [7:0] e);
    @(posedge sys_clk);
    mapRdAddr <= a;
    @(posedge sys_clk) #1;
    chk("map", 16'(mapRdData), 16'(e));
  endtask
  task automatic tScan();
    run(CMD_SCAN);
    mapChk(9'h000, 8'h02);
    mapChk(9'h001, 8'h01);
    chk("fill", 16'(fillValue), 16'h00F0);
    @(posedge sys_clk);
    cfg.fillF0 <= 1'b0;
    repeat (2) @(posedge sys_clk) #1;
    chk("fill0", 16'(fillValue), 16'h0000);
    $display("scan test done");
  endtask
  task automatic tProg();
    run(CMD_PROG);
    chk("pages", 16'(pIdx), 16'h0003);
    $display("skip program test done");
  endtask
  task automatic tErase();
    rsMode = 1'b1;
    pIdx = 0;
    run(CMD_ERASE);
    chk("restores", 16'(pIdx), 16'h0002);
    chk("erases", 16'(nErase), 16'h0010);
    $display("erase restore test done");
  endtask
  task automatic testDone();
    $display("checks %0d mismatches %0d", nTests, errCount);
    if (errCount == 0 && nTests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial begin
    rstn = 1'b0;
    opStart = 1'b0;
    opCmd = CMD_SCAN;
    progPages = 16'h0003;
    dataIn = 16'h00A5;
    dataInValid = 1'b1;
    mapRdAddr = 9'h000;
    cfg = '{MODE_SKIP, 1'b0, 1'b0, 1'b0, 1'b1, 3'h1, 1'b1, 13'h0010,
      13'h0010, 13'h0010};
    repeat (4) @(posedge sys_clk);
    rstn <= 1'b1;
    tScan();
    tProg();
    tErase();
    testDone();
  end
  // hang guard: all three runs need well under 5000 cycles
  initial begin
    #(25 * 12000);
    errCount++;
    testDone();
  end
endmodule
